/* rtl/obcl_apply.sv */
/*
  Decodes the hidden option copy into registered configuration outputs.
  Assumes load is a one-cycle pulse from the loader on the same clock.
*/
`timescale 1ns/1ps
module obcl_apply
   import obcl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [7:0] opt_byte,
   input  wire logic       stop_mode,
   output logic            wdog_timeout_action,
   output logic            wdog_always_on,
   output obcl_osc_t       osc_drive_select,
   output logic            brownout_en,
   output logic            code_read_en,
   output logic            debug_full_cmds,
   output logic            user_prog_en
);

   typedef struct packed {
      logic [7:0] opt;
      logic       bo_en;
   } obcl_apply_st_t;

   obcl_apply_st_t s_r;
   obcl_apply_st_t s_nxt;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (load) begin
         s_nxt.opt = opt_byte;
      end
      // brownout drops out only in stop mode and only when allowed
      s_nxt.bo_en = s_nxt.opt[OPT_BO_AON_BIT] | ~stop_mode;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '{opt: OPT_ERASED, bo_en: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign wdog_timeout_action = s_r.opt[OPT_WDOG_ACT_BIT];
   assign wdog_always_on      = ~s_r.opt[OPT_WDOG_AON_BIT];
   assign osc_drive_select    = obcl_osc_t'(s_r.opt[OPT_OSC_HI_BIT:OPT_OSC_LO_BIT]);
   assign brownout_en         = s_r.bo_en;
   assign code_read_en        = s_r.opt[OPT_READ_OPEN_BIT];
   assign debug_full_cmds     = s_r.opt[OPT_READ_OPEN_BIT];
   assign user_prog_en        = s_r.opt[OPT_WR_OPEN_BIT];

endmodule // obcl_apply

/* rtl/obcl_loader.sv */
/*
  Option byte configuration loader: on every reset it reads the option
  byte from flash, holds the core in reset until the hidden copy is
  applied, then distributes the settings and runs the watchdog policy.
  Assumes a same-clock byte flash read port answering with a valid
  strobe, an asynchronous reset pin, and an APB master on CLK.
*/
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module obcl_loader
   import obcl_pkg::*;
#(
   parameter int FLASH_AW = 16,
   parameter int PADDR_W  = 12
)
(
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic                PIN_RST_N,
   input  wire logic                STOP_RECOVERY,
   input  wire logic                STOP_MODE,
   input  wire logic                WDOG_TIMEOUT,
   output logic                     FLASH_RD_REQ,
   output logic [FLASH_AW-1:0]      FLASH_RD_ADDR,
   input  wire logic [7:0]          FLASH_RD_DATA,
   input  wire logic                FLASH_RD_VALID,
   output logic                     CORE_RST_HOLD,
   output logic                     LOAD_DONE,
   output logic                     WDOG_RUNNING,
   output logic                     WDOG_IRQ,
   output logic                     WDOG_RST_REQ,
   output obcl_osc_t                OSC_DRIVE_SEL,
   output logic                     BROWNOUT_EN,
   output logic                     CODE_READ_EN,
   output logic                     DEBUG_FULL_CMDS,
   output logic                     USER_PROG_EN,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [PADDR_W-1:0]  PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic [31:0]              PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR
);

   // -------------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------------
   if (FLASH_AW < 1 || FLASH_AW > 16) begin : g_bad_flash_aw
      $error("FLASH_AW must be 1 to 16");
   end
   if (PADDR_W < 4 || PADDR_W > 12) begin : g_bad_paddr_w
      $error("PADDR_W must be 4 to 12");
   end

   // -------------------------------------------------------------------
   // register decode
   // -------------------------------------------------------------------
   // only loader state is mapped; the option copy has no address at all
   function automatic logic [1:0] reg_sel(input logic [PADDR_W-1:0] addr);
      logic [11:0] a;
      a = 12'(addr);
      if (a == REG_STATUS) begin
         reg_sel = 2'h1;
      end else if (a == REG_WDOG_CMD) begin
         reg_sel = 2'h2;
      end else if (a == REG_LOAD_INFO) begin
         reg_sel = 2'h3;
      end else begin
         reg_sel = 2'h0;
      end
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      obcl_state_t st;
      logic        pin_ff1;
      logic        pin_ff2;
      logic        rd_req;
      logic [7:0]  opt;
      logic        load_pls;
      logic        done_pls;
      logic        wdog_run;
      logic        wdog_irq;
      logic        wdog_rst;
      logic [7:0]  reload_cnt;
      logic [7:0]  last_opt_seen;
      logic        rsvd_bad;
      logic [31:0] prdata;
      logic        slverr;
   } obcl_st_t;

   localparam obcl_st_t ST_RST = '{
      st:            OBCL_FETCH,
      pin_ff1:       1'b1,
      pin_ff2:       1'b1,
      rd_req:        1'b0,
      opt:           OPT_ERASED,
      load_pls:      1'b0,
      done_pls:      1'b0,
      wdog_run:      1'b0,
      wdog_irq:      1'b0,
      wdog_rst:      1'b0,
      reload_cnt:    RELOAD_CNT_RST,
      last_opt_seen: OPT_ERASED,
      rsvd_bad:      1'b0,
      prdata:        32'h0000_0000,
      slverr:        1'b0
   };

   obcl_st_t s_r;
   obcl_st_t s_nxt;

   logic      act_is_reset;
   logic      wdog_aon;
   logic      pin_rst;
   logic      restart;
   logic      apb_setup;
   logic      apb_write;
   logic [1:0] sel;

   // -------------------------------------------------------------------
   // option decode
   // -------------------------------------------------------------------
   obcl_apply u_apply (
      .clk                 (CLK),
      .rst                 (RST),
      .load                (s_r.load_pls),
      .opt_byte            (s_r.opt),
      .stop_mode           (STOP_MODE),
      .wdog_timeout_action (act_is_reset),
      .wdog_always_on      (wdog_aon),
      .osc_drive_select    (OSC_DRIVE_SEL),
      .brownout_en         (BROWNOUT_EN),
      .code_read_en        (CODE_READ_EN),
      .debug_full_cmds     (DEBUG_FULL_CMDS),
      .user_prog_en        (USER_PROG_EN)
   );

   // -------------------------------------------------------------------
   // restart sources
   // -------------------------------------------------------------------
   // pin level only after two flops; held low keeps the loader restarting
   assign pin_rst = ~s_r.pin_ff2;
   // a watchdog reset loops back through the same load sequence
   assign restart = pin_rst | STOP_RECOVERY | s_r.wdog_rst;

   assign apb_setup = PSEL & ~PENABLE;
   assign apb_write = PSEL & PENABLE & PWRITE;
   assign sel       = reg_sel(PADDR);

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      s_nxt          = s_r;
      s_nxt.pin_ff1  = PIN_RST_N;
      s_nxt.pin_ff2  = s_r.pin_ff1;
      s_nxt.load_pls = 1'b0;
      s_nxt.done_pls = 1'b0;
      s_nxt.wdog_irq = 1'b0;
      s_nxt.wdog_rst = 1'b0;

      // ---------------- load sequence ----------------
      case (s_r.st)
         OBCL_FETCH: begin
            // the flash port is read-only; no write path exists here
            s_nxt.rd_req = 1'b1;
            s_nxt.st     = OBCL_WAIT;
         end
         OBCL_WAIT: begin
            if (FLASH_RD_VALID && s_r.rd_req) begin
               s_nxt.rd_req        = 1'b0;
               s_nxt.opt           = FLASH_RD_DATA;
               s_nxt.last_opt_seen = FLASH_RD_DATA;
               s_nxt.rsvd_bad      = ~FLASH_RD_DATA[OPT_RSVD_BIT];
               s_nxt.load_pls      = 1'b1;
               s_nxt.st            = OBCL_APPLY;
            end
         end
         OBCL_APPLY: begin
            // decoder registers the copy this edge; release comes on the same edge
            s_nxt.done_pls   = 1'b1;
            s_nxt.reload_cnt = s_r.reload_cnt + 8'h01;
            s_nxt.wdog_run   = ~s_r.opt[OPT_WDOG_AON_BIT];
            s_nxt.st         = OBCL_RUN;
         end
         OBCL_RUN: begin
            // nothing rereads flash while running, so a reprogrammed
            // option byte waits for the next reset
            s_nxt.st = OBCL_RUN;
         end
         default: begin
            s_nxt.st = OBCL_FETCH;
         end
      endcase

      // ---------------- watchdog policy ----------------
      if (s_r.st == OBCL_RUN) begin
         if (apb_write && sel == 2'h2 && PWDATA[CMD_WDOG_START]) begin
            s_nxt.wdog_run = 1'b1;
         end
         // no disable path exists: only a restart stops it
         if (wdog_aon) begin
            s_nxt.wdog_run = 1'b1;
         end
         if (WDOG_TIMEOUT && s_r.wdog_run) begin
            if (act_is_reset) begin
               s_nxt.wdog_rst = 1'b1;
            end else begin
               s_nxt.wdog_irq = 1'b1;
            end
         end
      end

      // ---------------- any reset type restarts the load ----------------
      if (restart) begin
         s_nxt.st       = OBCL_FETCH;
         s_nxt.rd_req   = 1'b0;
         s_nxt.wdog_run = 1'b0;
         s_nxt.load_pls = 1'b0;
         s_nxt.done_pls = 1'b0;
         s_nxt.wdog_irq = 1'b0;
      end

      // ---------------- apb slave ----------------
      // read data and error are latched in setup so the access phase
      // answers at once with flop-driven data
      if (apb_setup) begin
         s_nxt.prdata = 32'h0000_0000;
         s_nxt.slverr = 1'b0;
         if (sel == 2'h1) begin
            s_nxt.prdata[STAT_DONE_BIT]    = (s_r.st == OBCL_RUN);
            s_nxt.prdata[STAT_WDOG_BIT]    = s_r.wdog_run;
            s_nxt.prdata[STAT_LOADING_BIT] = (s_r.st != OBCL_RUN);
            s_nxt.prdata[3]                = s_r.rsvd_bad;
         end else if (sel == 2'h2) begin
            // command register is write-only and reads as zero
            s_nxt.prdata = 32'h0000_0000;
         end else if (sel == 2'h3) begin
            s_nxt.prdata[7:0] = s_r.reload_cnt;
         end else begin
            s_nxt.slverr = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign FLASH_RD_REQ  = s_r.rd_req;
   assign FLASH_RD_ADDR = FLASH_AW'(OPT_BYTE_ADDR);
   // core stays held from reset through the apply cycle
   assign CORE_RST_HOLD = (s_r.st != OBCL_RUN);
   assign LOAD_DONE     = s_r.done_pls;
   assign WDOG_RUNNING  = s_r.wdog_run;
   assign WDOG_IRQ      = s_r.wdog_irq;
   assign WDOG_RST_REQ  = s_r.wdog_rst;
   assign PRDATA        = s_r.prdata;
   assign PREADY        = 1'b1;
   assign PSLVERR       = PSEL & PENABLE & s_r.slverr;

endmodule // obcl_loader

/* rtl/obcl_pkg.sv */
/*
  Shared constants for the option byte configuration loader: flash
  locations, option field positions, erased defaults, APB register map
  and loader states.
  Assumes a byte-wide flash read port and a 32-bit APB register bus.
*/
package obcl_pkg;

   // -------------------------------------------------------------------
   // flash locations
   // -------------------------------------------------------------------
   localparam logic [15:0] OPT_BYTE_ADDR  = 16'h0000;
   localparam logic [15:0] OPT_SPARE_ADDR = 16'h0001;

   // -------------------------------------------------------------------
   // option byte fields
   // -------------------------------------------------------------------
   localparam int OPT_WDOG_ACT_BIT  = 7;
   localparam int OPT_WDOG_AON_BIT  = 6;
   localparam int OPT_OSC_HI_BIT    = 5;
   localparam int OPT_OSC_LO_BIT    = 4;
   localparam int OPT_BO_AON_BIT    = 3;
   localparam int OPT_READ_OPEN_BIT = 2;
   localparam int OPT_RSVD_BIT      = 1;
   localparam int OPT_WR_OPEN_BIT   = 0;
   localparam logic [7:0] OPT_ERASED = 8'hFF;

   typedef enum logic [1:0] {
      OBCL_OSC_RC   = 2'h0,
      OBCL_OSC_LOW  = 2'h1,
      OBCL_OSC_MED  = 2'h2,
      OBCL_OSC_HIGH = 2'h3
   } obcl_osc_t;

   // -------------------------------------------------------------------
   // apb register map
   // -------------------------------------------------------------------
   localparam logic [11:0] REG_STATUS    = 12'h000;
   localparam logic [11:0] REG_WDOG_CMD  = 12'h004;
   localparam logic [11:0] REG_LOAD_INFO = 12'h008;

   localparam int STAT_DONE_BIT    = 0;
   localparam int STAT_WDOG_BIT    = 1;
   localparam int STAT_LOADING_BIT = 2;
   localparam int CMD_WDOG_START   = 0;
   localparam logic [7:0] RELOAD_CNT_RST = 8'h00;

   // -------------------------------------------------------------------
   // loader states
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      OBCL_FETCH = 4'h1,
      OBCL_WAIT  = 4'h2,
      OBCL_APPLY = 4'h4,
      OBCL_RUN   = 4'h8
   } obcl_state_t;

endpackage

/* tb/obcl_flash_model.sv */
/*
  Behavioural flash read side holding the two option locations.
  Assumes a same-clock byte read request held until the valid strobe.
*/
`timescale 1ns/1ps
module obcl_flash_model (
   input  wire logic        clk,
   input  wire logic        rd_req,
   input  wire logic [15:0] rd_addr,
   input  wire logic [7:0]  opt_byte,
   input  wire logic [7:0]  delay,
   output logic [7:0]       rd_data,
   output logic             rd_valid
);
   logic [7:0] cnt_r;
   logic       served_r;
   initial begin
      rd_data = 8'h00;
      rd_valid = 1'b0;
      cnt_r = 8'h00;
      served_r = 1'b0;
   end
   // no write path: stored bytes survive every reset
   always @(posedge clk) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data; // released bus inverts every cycle, so the old byte shows every other cycle
      if (!rd_req) begin
         cnt_r <= 8'h00;
         served_r <= 1'b0;
      end else if (!served_r && cnt_r == delay) begin
         rd_valid <= 1'b1;
         served_r <= 1'b1;
         rd_data <= (rd_addr == 16'h0001) ? 8'hFF : opt_byte;
      end else
         cnt_r <= cnt_r + 8'h01;
   end
endmodule // obcl_flash_model

/* tb/obcl_loader_assertions.sv */
/*
  Port-level checks for the option byte loader, bound into obcl_loader.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module obcl_loader_assertions
   import obcl_pkg::*;
#(
   parameter int FLASH_AW = 16,
   parameter int PADDR_W  = 12
)
(
   input wire logic                CLK,
   input wire logic                RST,
   input wire logic                STOP_RECOVERY,
   input wire logic                STOP_MODE,
   input wire logic                WDOG_TIMEOUT,
   input wire logic                FLASH_RD_REQ,
   input wire logic [FLASH_AW-1:0] FLASH_RD_ADDR,
   input wire logic [7:0]          FLASH_RD_DATA,
   input wire logic                FLASH_RD_VALID,
   input wire logic                CORE_RST_HOLD,
   input wire logic                LOAD_DONE,
   input wire logic                WDOG_RUNNING,
   input wire logic                WDOG_IRQ,
   input wire logic                WDOG_RST_REQ,
   input wire obcl_osc_t           OSC_DRIVE_SEL,
   input wire logic                BROWNOUT_EN,
   input wire logic                CODE_READ_EN,
   input wire logic                DEBUG_FULL_CMDS,
   input wire logic                USER_PROG_EN,
   input wire logic                PSEL,
   input wire logic                PENABLE,
   input wire logic                PWRITE,
   input wire logic [PADDR_W-1:0]  PADDR,
   input wire logic [31:0]         PWDATA,
   input wire logic [31:0]         PRDATA,
   input wire logic                PSLVERR
);
   // -----------------------------------------------------------------
   // shadow of the byte the loader took from flash
   // -----------------------------------------------------------------
   logic [7:0] opt_r;
   logic       cmd_r;
   logic       unmapped;
   assign unmapped = !(PADDR inside {REG_STATUS, REG_WDOG_CMD, REG_LOAD_INFO});
   always_ff @(posedge CLK) begin
      if (RST)
         opt_r <= OPT_ERASED;
      else if (FLASH_RD_VALID && FLASH_RD_REQ)
         opt_r <= FLASH_RD_DATA;
   end
   always_ff @(posedge CLK) begin
      cmd_r <= PSEL && PENABLE && PWRITE && (PADDR == REG_WDOG_CMD) && PWDATA[CMD_WDOG_START];
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_release; $fell(CORE_RST_HOLD) |-> LOAD_DONE; endproperty
   property p_loaded; LOAD_DONE |-> $past(FLASH_RD_VALID, 2) && $past(FLASH_RD_REQ, 2);
   endproperty
   property p_addr; FLASH_RD_REQ |-> FLASH_RD_ADDR == OPT_BYTE_ADDR; endproperty
   property p_stop; STOP_RECOVERY |-> ##[1:2] CORE_RST_HOLD; endproperty
   property p_osc; LOAD_DONE |-> OSC_DRIVE_SEL == opt_r[5:4]; endproperty
   property p_read; LOAD_DONE |-> CODE_READ_EN == opt_r[2] && DEBUG_FULL_CMDS == opt_r[2];
   endproperty
   property p_prog; LOAD_DONE |-> USER_PROG_EN == opt_r[0]; endproperty
   property p_bo;
      !CORE_RST_HOLD && !$past(CORE_RST_HOLD) |-> BROWNOUT_EN == (opt_r[3] || !$past(STOP_MODE));
   endproperty
   property p_tmo;
      WDOG_TIMEOUT && WDOG_RUNNING && !CORE_RST_HOLD
      |=> (opt_r[7] ? (WDOG_RST_REQ && !WDOG_IRQ) : (WDOG_IRQ && !WDOG_RST_REQ));
   endproperty
   property p_wrst; WDOG_RST_REQ |-> ##[1:3] CORE_RST_HOLD; endproperty
   property p_aon; !opt_r[6] && !CORE_RST_HOLD && !$past(CORE_RST_HOLD, 2) |-> WDOG_RUNNING;
   endproperty
   property p_cmd; $rose(WDOG_RUNNING) && opt_r[6] |-> cmd_r; endproperty
   property p_unmap; PSEL && PENABLE && unmapped |-> PSLVERR && PRDATA == 32'h0; endproperty

   a_release: assert property (p_release) else $error("core freed early");
   a_loaded: assert property (p_loaded) else $error("done without read");
   a_addr: assert property (p_addr) else $error("bad flash addr");
   a_stop: assert property (p_stop) else $error("no reload on stop");
   a_osc: assert property (p_osc) else $error("osc mismatch");
   a_read: assert property (p_read) else $error("read enable mismatch");
   a_prog: assert property (p_prog) else $error("prog enable mismatch");
   a_bo: assert property (p_bo) else $error("brownout mismatch");
   a_tmo: assert property (p_tmo) else $error("timeout action wrong");
   a_wrst: assert property (p_wrst) else $error("no reload on wdog reset");
   a_aon: assert property (p_aon) else $error("wdog not running");
   a_cmd: assert property (p_cmd) else $error("wdog started uncommanded");
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");

   c_load: cover property (LOAD_DONE);
   c_irq: cover property (WDOG_IRQ);
   c_err: cover property (PSLVERR);
endmodule // obcl_loader_assertions

bind obcl_loader obcl_loader_assertions #(.FLASH_AW(FLASH_AW), .PADDR_W(PADDR_W))
   obcl_loader_assertions_inst (.CLK(CLK), .RST(RST), .STOP_RECOVERY(STOP_RECOVERY),
   .STOP_MODE(STOP_MODE), .WDOG_TIMEOUT(WDOG_TIMEOUT), .FLASH_RD_REQ(FLASH_RD_REQ),
   .FLASH_RD_ADDR(FLASH_RD_ADDR), .FLASH_RD_DATA(FLASH_RD_DATA),
   .FLASH_RD_VALID(FLASH_RD_VALID), .CORE_RST_HOLD(CORE_RST_HOLD), .LOAD_DONE(LOAD_DONE),
   .WDOG_RUNNING(WDOG_RUNNING), .WDOG_IRQ(WDOG_IRQ), .WDOG_RST_REQ(WDOG_RST_REQ),
   .OSC_DRIVE_SEL(OSC_DRIVE_SEL), .BROWNOUT_EN(BROWNOUT_EN), .CODE_READ_EN(CODE_READ_EN),
   .DEBUG_FULL_CMDS(DEBUG_FULL_CMDS), .USER_PROG_EN(USER_PROG_EN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR));

/* tb/obcl_loader_tb_top.sv */
/*
  Self-checking bench for the option byte loader with a flash model.
  Assumes a 125 MHz clock and the zero-wait APB slave of the loader.
*/
`timescale 1ns/1ps
module obcl_loader_tb_top import obcl_pkg::*;;
   logic CLK, RST, PIN_RST_N, STOP_RECOVERY, STOP_MODE, WDOG_TIMEOUT, FLASH_RD_REQ;
   logic FLASH_RD_VALID, CORE_RST_HOLD, LOAD_DONE, WDOG_RUNNING, WDOG_IRQ, WDOG_RST_REQ;
   logic BROWNOUT_EN, CODE_READ_EN, DEBUG_FULL_CMDS, USER_PROG_EN, PSEL, PENABLE, PWRITE;
   logic        PREADY, PSLVERR, e;
   logic [15:0] FLASH_RD_ADDR;
   logic [7:0]  FLASH_RD_DATA, opt_mem, rd_dly;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, q;
   obcl_osc_t   OSC_DRIVE_SEL;
   int          n_errors = 0;
   int          cmp_count = 0;
   typedef struct packed {logic [7:0] opt; logic [1:0] osc; logic bo, rd, pe;} obcl_row_t;
   // reserved bit kept at one in every byte
   obcl_row_t rows [4] = '{'{8'hFF, 2'h3, 1'b1, 1'b1, 1'b1}, '{8'hC2, 2'h0, 1'b0, 1'b0, 1'b0},
                           '{8'hDB, 2'h1, 1'b1, 1'b0, 1'b1}, '{8'hE6, 2'h2, 1'b0, 1'b1, 1'b0}};

   obcl_loader obcl_loader_inst (.CLK(CLK), .RST(RST), .PIN_RST_N(PIN_RST_N),
      .STOP_RECOVERY(STOP_RECOVERY), .STOP_MODE(STOP_MODE), .WDOG_TIMEOUT(WDOG_TIMEOUT),
      .FLASH_RD_REQ(FLASH_RD_REQ), .FLASH_RD_ADDR(FLASH_RD_ADDR),
      .FLASH_RD_DATA(FLASH_RD_DATA), .FLASH_RD_VALID(FLASH_RD_VALID),
      .CORE_RST_HOLD(CORE_RST_HOLD), .LOAD_DONE(LOAD_DONE), .WDOG_RUNNING(WDOG_RUNNING),
      .WDOG_IRQ(WDOG_IRQ), .WDOG_RST_REQ(WDOG_RST_REQ), .OSC_DRIVE_SEL(OSC_DRIVE_SEL),
      .BROWNOUT_EN(BROWNOUT_EN), .CODE_READ_EN(CODE_READ_EN),
      .DEBUG_FULL_CMDS(DEBUG_FULL_CMDS), .USER_PROG_EN(USER_PROG_EN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR));
   obcl_flash_model obcl_flash_model_inst (.clk(CLK), .rd_req(FLASH_RD_REQ),
      .rd_addr(FLASH_RD_ADDR), .opt_byte(opt_mem), .delay(rd_dly),
      .rd_data(FLASH_RD_DATA), .rd_valid(FLASH_RD_VALID));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_load();
      int n;
      n = 0;
      do begin @(negedge CLK); n++; end while (LOAD_DONE !== 1'b1 && n < 100);
      chk("load_done", LOAD_DONE, 1'b1);
      chk("core_hold", CORE_RST_HOLD, 1'b0);
   endtask
   task automatic strobe(input bit rec);
      @(posedge CLK);
      if (rec)
         STOP_RECOVERY <= 1'b1;
      else
         WDOG_TIMEOUT <= 1'b1;
      @(posedge CLK);
      STOP_RECOVERY <= 1'b0;
      WDOG_TIMEOUT <= 1'b0;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 20);
      chk("pready", PREADY, 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      {RST, PIN_RST_N, STOP_MODE} = 3'b111;
      {STOP_RECOVERY, WDOG_TIMEOUT, PSEL, PENABLE, PWRITE} = 5'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      opt_mem = 8'hFF;
      rd_dly = 8'h03;
      repeat (12) @(posedge CLK);
      chk("hold_rst", CORE_RST_HOLD, 1'b1);
      chk("osc_rst", OSC_DRIVE_SEL, OBCL_OSC_HIGH);
      RST <= 1'b0;
      wait_load();
      for (int i = 0; i < 4; i++) begin
         opt_mem <= rows[i].opt;
         rd_dly <= 8'(4 + 5 * i);
         strobe(1'b1);
         repeat (2) @(negedge CLK);
         chk("hold_wait", CORE_RST_HOLD, 1'b1);
         wait_load();
         @(negedge CLK);
         chk("osc", OSC_DRIVE_SEL, rows[i].osc);
         chk("brownout", BROWNOUT_EN, rows[i].bo);
         chk("read_en", CODE_READ_EN, rows[i].rd);
         chk("debug", DEBUG_FULL_CMDS, rows[i].rd);
         chk("prog_en", USER_PROG_EN, rows[i].pe);
      end
      // new flash byte must wait for a reset
      @(posedge CLK);
      opt_mem <= 8'h3E;
      STOP_MODE <= 1'b0;
      repeat (30) @(negedge CLK);
      chk("osc_kept", OSC_DRIVE_SEL, OBCL_OSC_MED);
      chk("bo_run", BROWNOUT_EN, 1'b1);
      @(posedge CLK);
      PIN_RST_N <= 1'b0;
      repeat (4) @(posedge CLK);
      PIN_RST_N <= 1'b1;
      wait_load();
      @(negedge CLK);
      chk("osc_pin", OSC_DRIVE_SEL, OBCL_OSC_HIGH);
      chk("prog_pin", USER_PROG_EN, 1'b0);
      chk("wdog_aon", WDOG_RUNNING, 1'b1);
      strobe(1'b0);
      @(negedge CLK);
      chk("irq", WDOG_IRQ, 1'b1);
      chk("no_rst", WDOG_RST_REQ, 1'b0);
      chk("aon_kept", WDOG_RUNNING, 1'b1);
      opt_mem <= 8'hFF;
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      wait_load();
      strobe(1'b0);
      @(negedge CLK);
      chk("idle_tmo", {WDOG_IRQ, WDOG_RST_REQ, WDOG_RUNNING}, 3'b000);
      apb(1'b1, REG_WDOG_CMD, 32'h1);
      @(negedge CLK);
      chk("wdog_cmd", WDOG_RUNNING, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", q, 32'h3);
      apb(1'b0, REG_LOAD_INFO, 32'h0);
      chk("loads", q, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmap_rd", q, 32'h0);
      chk("unmap_rd_err", e, 1'b1);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      chk("unmap_wr", e, 1'b1);
      strobe(1'b0);
      @(negedge CLK);
      chk("rst_req", {WDOG_RST_REQ, WDOG_IRQ}, 2'b10);
      wait_load();
      @(negedge CLK);
      chk("wdog_stop", WDOG_RUNNING, 1'b0);
      tally_and_finish();
   end
endmodule // obcl_loader_tb_top
